// ==== hdl/mdcc_drive.sv ====
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "mdcc_cfg.svh"
module mdcc_drive #(
  parameter int STANDSTILL_CYCLES = `MDCC_STANDSTILL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step_pulse_pos,
  input wire logic step_pulse_neg,
  input wire logic step_dir_pos,
  input wire logic step_dir_neg,
  input wire logic drive_enable_pos,
  input wire logic drive_enable_neg,
  input wire logic current_sel_bit0,
  input wire logic current_sel_bit1,
  input wire logic current_sel_bit2,
  input wire logic standstill_reduce_en,
  input wire logic microstep_sel_bit0,
  input wire logic microstep_sel_bit1,
  input wire logic microstep_sel_bit2,
  input wire logic microstep_sel_bit3,
  input wire logic power_fault,
  output logic phase_enable,
  output logic step_advance,
  output logic step_forward,
  output logic [15:0] microstep_pos,
  output logic [15:0] steps_per_rev,
  output logic [12:0] phase_current_ma,
  output logic led_power,
  output logic led_fault,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  mdcc_pkg::mdcc_ctl_type ctl_raw;
  mdcc_pkg::mdcc_ctl_type ctl;
  mdcc_pkg::mdcc_settings_type sw_raw;
  mdcc_pkg::mdcc_settings_type sw;
  mdcc_pkg::mdcc_table_type tbl;

  // differential pair reads high only when truly driven apart
  assign ctl_raw.step = step_pulse_pos & ~step_pulse_neg;
  assign ctl_raw.dir = step_dir_pos & ~step_dir_neg;
  assign ctl_raw.enable = drive_enable_pos & ~drive_enable_neg;
  assign ctl_raw.fault = power_fault;

  // switch bank, off reads as one
  assign sw_raw = {microstep_sel_bit3, microstep_sel_bit2, microstep_sel_bit1,
    microstep_sel_bit0, standstill_reduce_en, current_sel_bit2, current_sel_bit1,
    current_sel_bit0}; // RULE_01

  mdcc_sync #(
    .W(4)
  ) u_ctl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(ctl_raw),
    .level_q(ctl)
  );

  mdcc_sync #(
    .W(8)
  ) u_sw_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sw_raw),
    .level_q(sw)
  );

  mdcc_table u_table (
    .pclk(pclk),
    .presetn(presetn),
    .settings(sw),
    .table_q(tbl)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [`MDCC_CTRL_W-1:0] ctrl_q;
  logic [`MDCC_IRQ_W-1:0] irq_stat_q;
  logic [`MDCC_IRQ_W-1:0] irq_mask_q;
  logic step_prev_q;
  logic fault_q;
  logic reduced_q;
  logic [22:0] idle_cnt_q;
  logic [3:0] ustep_prev_q;
  logic [15:0] pos_q;
  logic phase_enable_q;
  logic step_advance_q;
  logic step_forward_q;
  logic [12:0] cur_q;
  logic led_power_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // step, direction, enable, fault

  localparam logic [22:0] IDLE_LIMIT = 23'(STANDSTILL_CYCLES);

  wire rise_w = ctl.step & ~step_prev_q;
  wire fall_w = ~ctl.step & step_prev_q;
  wire edge_w = ctrl_q[`MDCC_CTRL_FALL_EDGE] ? fall_w : rise_w; // RULE_16
  wire dir_eff_w = ctl.dir ^ ctrl_q[`MDCC_CTRL_DIR_INV];
  wire fault_w = fault_q | ctl.fault;
  wire run_w = ctl.enable & ~fault_w; // RULE_09 RULE_13
  wire step_evt_w = edge_w & run_w; // RULE_07
  wire idle_w = (idle_cnt_q == IDLE_LIMIT);
  wire reduce_w = sw.reduce_en & idle_w & ~step_evt_w; // RULE_05 RULE_06
  wire moving_w = ~idle_w;
  wire ustep_chg_w = (ustep_prev_q != sw.ustep_code) & moving_w; // RULE_10
  wire [15:0] last_pos_w = tbl.steps_rev - 16'h0001;
  wire pos_top_w = (pos_q >= last_pos_w);
  wire pos_bot_w = (pos_q == 16'h0000) | (pos_q > last_pos_w);
  wire [15:0] pos_up_w = pos_top_w ? 16'h0000 : pos_q + 16'h0001;
  wire [15:0] pos_dn_w = pos_bot_w ? last_pos_w : pos_q - 16'h0001;
  wire [14:0] red_prod_w = 15'(tbl.peak_ma) * 15'(`MDCC_REDUCE_NUM);
  wire [12:0] red_ma_w = 13'(red_prod_w / 15'(`MDCC_REDUCE_DEN));
  wire [12:0] cur_d = reduced_q ? red_ma_w : tbl.peak_ma;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_prev_q <= 1'b0;
      fault_q <= 1'b0;
      reduced_q <= 1'b0;
      ustep_prev_q <= 4'h0;
    end
    else
    begin
      step_prev_q <= ctl.step;
      fault_q <= fault_w; // RULE_14
      reduced_q <= reduce_w; // RULE_15
      ustep_prev_q <= sw.ustep_code;
    end
  end

  // standstill timer restarts on each counted step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle_cnt_q <= 23'h000000;
    else if (step_evt_w)
      idle_cnt_q <= 23'h000000; // RULE_15
    else if (!idle_w)
      idle_cnt_q <= idle_cnt_q + 23'h000001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_q <= 16'h0000;
      step_forward_q <= 1'b0;
    end
    else if (step_evt_w)
    begin
      pos_q <= dir_eff_w ? pos_up_w : pos_dn_w; // RULE_07
      step_forward_q <= dir_eff_w; // RULE_08 RULE_16
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_enable_q <= 1'b0;
      step_advance_q <= 1'b0;
      cur_q <= 13'h0000;
      led_power_q <= 1'b1;
    end
    else
    begin
      phase_enable_q <= run_w; // RULE_09 RULE_13
      step_advance_q <= step_evt_w;
      cur_q <= cur_d; // RULE_06
      led_power_q <= 1'b1; // RULE_11
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states after setup

  wire setup_w = psel & ~penable;
  wire access_w = psel & penable & pready_q;
  wire wr_w = access_w & pwrite;
  wire rd_w = access_w & ~pwrite;
  wire hit_status_w = (paddr == `MDCC_OFS_STATUS);
  wire hit_pos_w = (paddr == `MDCC_OFS_POSITION);
  wire hit_stat_w = (paddr == `MDCC_OFS_IRQ_STAT);
  wire hit_mask_w = (paddr == `MDCC_OFS_IRQ_MASK);
  wire hit_ctrl_w = (paddr == `MDCC_OFS_CTRL);
  wire hit_steps_w = (paddr == `MDCC_OFS_STEPS);
  wire hit_cur_w = (paddr == `MDCC_OFS_CURRENT);
  wire [`MDCC_IRQ_W-1:0] irq_mask_d = (wr_w & hit_mask_w) ? pwdata[`MDCC_IRQ_W-1:0]
    : irq_mask_q;
  wire hit_any_w = hit_status_w | hit_pos_w | hit_stat_w | hit_mask_w | hit_ctrl_w
    | hit_steps_w | hit_cur_w;
  wire [31:0] status_w = {16'h0000, sw, 4'h0, reduced_q, fault_q, ctl.dir, ctl.enable};
  wire [31:0] rd_data_w =
    hit_status_w ? status_w :
    hit_pos_w ? {16'h0000, pos_q} :
    hit_stat_w ? {28'h0000000, irq_stat_q} :
    hit_mask_w ? {28'h0000000, irq_mask_q} :
    hit_ctrl_w ? {30'h00000000, ctrl_q} :
    hit_steps_w ? {16'h0000, tbl.steps_rev} :
    hit_cur_w ? {3'h0, tbl.peak_ma, 3'h0, cur_q} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= setup_w;
      pslverr_q <= setup_w & ~hit_any_w;
      prdata_q <= (setup_w & ~pwrite) ? rd_data_w : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `MDCC_RST_CTRL;
      irq_mask_q <= `MDCC_RST_IRQ_MASK;
    end
    else
    begin
      if (wr_w && hit_ctrl_w)
        ctrl_q <= pwdata[`MDCC_CTRL_W-1:0];
      irq_mask_q <= irq_mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts, read clears, new event wins

  wire [`MDCC_IRQ_W-1:0] irq_evt_w = {ustep_chg_w, reduce_w & ~reduced_q,
    ctl.fault & ~fault_q, step_evt_w};
  wire irq_clr_w = rd_w & hit_stat_w;
  wire [`MDCC_IRQ_W-1:0] irq_stat_d = (irq_clr_w ? '0 : irq_stat_q) | irq_evt_w;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_mask_d);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign phase_enable = phase_enable_q;
  assign step_advance = step_advance_q;
  assign step_forward = step_forward_q;
  assign microstep_pos = pos_q;
  assign steps_per_rev = tbl.steps_rev;
  assign phase_current_ma = cur_q;
  assign led_power = led_power_q;
  assign led_fault = fault_q; // RULE_12
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_fault_hold;
    fault_q |=> fault_q [*8];
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault state left"); // RULE_14

  property p_fault_led;
    ctl.fault |=> led_fault;
  endproperty
  a_fault_led: assert property (p_fault_led) else $error("red indicator not lit"); // RULE_12

  property p_fault_free;
    fault_q |=> !phase_enable && !step_advance;
  endproperty
  a_fault_free: assert property (p_fault_free) else $error("phases live in fault"); // RULE_13

  property p_power_led;
    $past(presetn) |-> led_power;
  endproperty
  a_power_led: assert property (p_power_led) else $error("green indicator dark"); // RULE_11

  property p_enable;
    (ctl.enable && !fault_w) |=> phase_enable;
  endproperty
  a_enable: assert property (p_enable) else $error("phases not enabled"); // RULE_09

  property p_step_one;
    step_evt_w |=> step_advance ##1 !step_advance;
  endproperty
  a_step_one: assert property (p_step_one) else $error("step not single"); // RULE_07

  property p_step_dir;
    step_evt_w |=> step_forward == $past(dir_eff_w);
  endproperty
  a_step_dir: assert property (p_step_dir) else $error("direction not sampled"); // RULE_16

  property p_pos_move;
    (step_evt_w && dir_eff_w && !pos_top_w) |=> microstep_pos == $past(pos_q) + 16'h0001;
  endproperty
  a_pos_move: assert property (p_pos_move) else $error("position not advanced"); // RULE_08

  property p_reduce;
    reduced_q |=> phase_current_ma == $past(red_ma_w);
  endproperty
  a_reduce: assert property (p_reduce) else $error("current not reduced"); // RULE_06

  property p_restore;
    step_evt_w |=> !reduced_q ##1 phase_current_ma == $past(tbl.peak_ma);
  endproperty
  a_restore: assert property (p_restore) else $error("full current not restored"); // RULE_15

  property p_no_reduce_off;
    !sw.reduce_en |=> !reduced_q;
  endproperty
  a_no_reduce_off: assert property (p_no_reduce_off) else $error("reduction while off"); // RULE_05

  property p_irq_level;
    irq == (|(irq_stat_q & irq_mask_q));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  c_step: cover property (step_evt_w ##1 step_advance);
  c_reduce: cover property ($rose(reduced_q));
  c_fault: cover property ($rose(fault_q));
  c_irq_read: cover property (irq_clr_w && irq_stat_q != '0);

endmodule : mdcc_drive

// ==== hdl/mdcc_cfg.svh ====
// Operation
// [RULE_01] eight switches: current, reduction, microstep
// [RULE_02] sixteen microstep resolutions up to 51200
// [RULE_03] microstep code maps to steps per revolution
// [RULE_04] three-bit current code, 2.40 to 7.20 A
// [RULE_05] switch four enables standstill reduction
// [RULE_06] idle 0.4 s lowers current to 60 percent
// [RULE_07] one microstep per step pulse
// [RULE_08] direction input sets step direction
// [RULE_09] enable input gates motor phases
// [RULE_10] controller keeps microstep setting while moving; the code applies a change at once and only raises an interrupt
// [RULE_11] green indicator lit while powered
// [RULE_12] red indicator lit in fault state
// [RULE_13] fault de-energises the motor phases
// [RULE_14] fault held until power cycle
// [RULE_15] step restarts timer, restores full current
// [RULE_16] count chosen edge, sample direction then
`ifndef MDCC_CFG_SVH
`define MDCC_CFG_SVH

`define MDCC_OFS_STATUS 8'h00
`define MDCC_OFS_POSITION 8'h04
`define MDCC_OFS_IRQ_STAT 8'h08
`define MDCC_OFS_IRQ_MASK 8'h0C
`define MDCC_OFS_CTRL 8'h10
`define MDCC_OFS_STEPS 8'h14
`define MDCC_OFS_CURRENT 8'h18

`define MDCC_IRQ_STEP 0
`define MDCC_IRQ_FAULT 1
`define MDCC_IRQ_REDUCE 2
`define MDCC_IRQ_USTEP_MOVE 3
`define MDCC_IRQ_W 4

`define MDCC_CTRL_FALL_EDGE 0
`define MDCC_CTRL_DIR_INV 1
`define MDCC_CTRL_W 2

`define MDCC_RST_IRQ_MASK 4'h0
`define MDCC_RST_CTRL 2'h0

`define MDCC_REDUCE_NUM 3
`define MDCC_REDUCE_DEN 5
`define MDCC_CLK_HZ 20000000
`define MDCC_STANDSTILL_MS 400
`define MDCC_STANDSTILL_CYC (`MDCC_STANDSTILL_MS * (`MDCC_CLK_HZ / 1000))

`endif

// ==== hdl/mdcc_pkg.sv ====
package mdcc_pkg;

  // switch bank as read, off reads as one
  typedef struct packed {
    logic [3:0] ustep_code;
    logic reduce_en;
    logic [2:0] cur_code;
  } mdcc_settings_type;

  // decoded settings
  typedef struct packed {
    logic [15:0] steps_rev;
    logic [12:0] peak_ma;
  } mdcc_table_type;

  // synchronised control inputs
  typedef struct packed {
    logic fault;
    logic enable;
    logic dir;
    logic step;
  } mdcc_ctl_type;

endpackage : mdcc_pkg

// ==== hdl/mdcc_sync.sv ====
`timescale 1ns/1ps
module mdcc_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // level moves only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= (level_q & (s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q));
    end
  end

endmodule : mdcc_sync

// ==== hdl/mdcc_table.sv ====
`timescale 1ns/1ps
module mdcc_table (
  input wire logic pclk,
  input wire logic presetn,
  input wire mdcc_pkg::mdcc_settings_type settings,
  output mdcc_pkg::mdcc_table_type table_q
);

  mdcc_pkg::mdcc_table_type table_d;

  always_comb
  begin
    table_d = '0;
    case (settings.ustep_code) // RULE_02 RULE_03
      4'h0: table_d.steps_rev = 16'd400;
      4'h1: table_d.steps_rev = 16'd800;
      4'h2: table_d.steps_rev = 16'd1600;
      4'h3: table_d.steps_rev = 16'd3200;
      4'h4: table_d.steps_rev = 16'd6400;
      4'h5: table_d.steps_rev = 16'd12800;
      4'h6: table_d.steps_rev = 16'd25600;
      4'h7: table_d.steps_rev = 16'd51200;
      4'h8: table_d.steps_rev = 16'd1000;
      4'h9: table_d.steps_rev = 16'd2000;
      4'hA: table_d.steps_rev = 16'd4000;
      4'hB: table_d.steps_rev = 16'd5000;
      4'hC: table_d.steps_rev = 16'd8000;
      4'hD: table_d.steps_rev = 16'd10000;
      4'hE: table_d.steps_rev = 16'd20000;
      default: table_d.steps_rev = 16'd40000;
    endcase
    // peak current in milliamps
    case (settings.cur_code) // RULE_04
      3'h0: table_d.peak_ma = 13'd2400;
      3'h1: table_d.peak_ma = 13'd3080;
      3'h2: table_d.peak_ma = 13'd3770;
      3'h3: table_d.peak_ma = 13'd4450;
      3'h4: table_d.peak_ma = 13'd5140;
      3'h5: table_d.peak_ma = 13'd5830;
      3'h6: table_d.peak_ma = 13'd6520;
      default: table_d.peak_ma = 13'd7200;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      table_q <= '0;
    else
      table_q <= table_d;
  end

endmodule : mdcc_table

// ==== verif/mdcc_ctrl_model.sv ====
`timescale 1ns/1ps
module mdcc_ctrl_model (
  input wire logic pclk,
  output logic step_pulse_pos,
  output logic step_pulse_neg,
  output logic step_dir_pos,
  output logic step_dir_neg,
  output logic drive_enable_pos,
  output logic drive_enable_neg
);
  logic step_lvl = 1'b0;
  logic dir_lvl = 1'b1;
  logic en_lvl = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // negative leg is always the complement
  assign step_pulse_pos = step_lvl;
  assign step_pulse_neg = ~step_lvl;
  assign step_dir_pos = dir_lvl;
  assign step_dir_neg = ~dir_lvl;
  assign drive_enable_pos = en_lvl;
  assign drive_enable_neg = ~en_lvl;
  ////////////////////////////////////////////////////////////////////////////////
  // direction only moves while the step line rests low
  task drive(input logic en, input logic dir);
    @(posedge pclk);
    en_lvl <= en;
    dir_lvl <= dir;
  endtask : drive
  // each level held six cycles, beyond the sync depth
  task pulse(input int n);
    for (int i = 0; i < n; i++)
    begin
      repeat (6) @(posedge pclk);
      step_lvl <= 1'b1;
      repeat (6) @(posedge pclk);
      step_lvl <= 1'b0;
    end
  endtask : pulse
endmodule : mdcc_ctrl_model

// ==== verif/microstep_drive_config_ctrl_test.sv ====
`timescale 1ns/1ps
module microstep_drive_config_ctrl_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0] cur_sw;
  logic red_sw;
  logic [3:0] us_sw;
  logic power_fault;
  wire current_sel_bit0 = cur_sw[0];
  wire current_sel_bit1 = cur_sw[1];
  wire current_sel_bit2 = cur_sw[2];
  wire standstill_reduce_en = red_sw;
  wire microstep_sel_bit0 = us_sw[0];
  wire microstep_sel_bit1 = us_sw[1];
  wire microstep_sel_bit2 = us_sw[2];
  wire microstep_sel_bit3 = us_sw[3];
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic step_pulse_pos;
  logic step_pulse_neg;
  logic step_dir_pos;
  logic step_dir_neg;
  logic drive_enable_pos;
  logic drive_enable_neg;
  logic phase_enable;
  logic step_advance;
  logic step_forward;
  logic [15:0] microstep_pos;
  logic [15:0] steps_per_rev;
  logic [12:0] phase_current_ma;
  logic led_power;
  logic led_fault;
  logic irq;
  int bad_count = 0;
  int n_checks = 0;
  int adv_n = 0;
  logic [31:0] rd;
  logic err;
  logic [15:0] steps_tab [16] = '{16'h0190, 16'h0320, 16'h0640, 16'h0C80, 16'h1900, 16'h3200,
    16'h6400, 16'hC800, 16'h03E8, 16'h07D0, 16'h0FA0, 16'h1388, 16'h1F40, 16'h2710, 16'h4E20,
    16'h9C40};
  logic [12:0] ma_tab [8] = '{13'h0960, 13'h0C08, 13'h0EBA, 13'h1162, 13'h1414, 13'h16C6,
    13'h1978, 13'h1C20};

  initial forever #25 pclk = ~pclk;
  always @(posedge pclk) if (step_advance === 1'b1) adv_n <= adv_n + 1;

  mdcc_drive #(.STANDSTILL_CYCLES(50)) i_dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .step_pulse_pos, .step_pulse_neg,
    .step_dir_pos, .step_dir_neg, .drive_enable_pos, .drive_enable_neg,
    .current_sel_bit0, .current_sel_bit1, .current_sel_bit2, .standstill_reduce_en,
    .microstep_sel_bit0, .microstep_sel_bit1, .microstep_sel_bit2, .microstep_sel_bit3,
    .power_fault, .phase_enable,
    .step_advance, .step_forward, .microstep_pos, .steps_per_rev, .phase_current_ma, .led_power,
    .led_fault, .irq);
  mdcc_ctrl_model i_ctl (.pclk, .step_pulse_pos, .step_pulse_neg, .step_dir_pos,
    .step_dir_neg, .drive_enable_pos, .drive_enable_neg);

  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_val
  task chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      bad_count++;
      wrap_up;
    end
  endtask : apb
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cur_sw <= 3'h0;
    red_sw <= 1'b0;
    us_sw <= 4'h0;
    power_fault <= 1'b0;
    idle(20);
    presetn <= 1'b1;
    idle(10);
    chk_bit("led_power", 1'b1, led_power);
    chk_bit("led_fault", 1'b0, led_fault);
    apb(1'b0, 8'h0C, 32'h0);
    chk_val("mask reset", 32'h0, rd);
    apb(1'b0, 8'hFC, 32'h0);
    chk_bit("unmapped err", 1'b1, err);
    chk_val("unmapped data", 32'h0, rd);
    $display("test reset done");
    // motor idle during every switch change
    for (int u = 0; u < 16; u++)
    begin
      us_sw <= u[3:0];
      idle(10);
      chk_val("steps_per_rev", 32'(steps_tab[u]), 32'(steps_per_rev));
    end
    us_sw <= 4'h0;
    for (int c = 0; c < 8; c++)
    begin
      cur_sw <= c[2:0];
      idle(10);
      chk_val("current", 32'(ma_tab[c]), 32'(phase_current_ma));
      apb(1'b0, 8'h00, 32'h0);
      chk_val("switch field", 32'({us_sw, red_sw, cur_sw}), 32'(rd[15:8]));
    end
    idle(60);
    chk_val("no reduction", 32'h1C20, 32'(phase_current_ma));
    $display("test tables done");
    i_ctl.drive(1'b1, 1'b1);
    idle(8);
    chk_bit("phase_enable", 1'b1, phase_enable);
    i_ctl.pulse(3);
    idle(4);
    chk_val("pos forward", 32'h3, 32'(microstep_pos));
    chk_val("advance count", 32'h3, 32'(adv_n));
    chk_bit("forward", 1'b1, step_forward);
    i_ctl.drive(1'b1, 1'b0);
    i_ctl.pulse(4);
    idle(4);
    chk_val("pos wrap", 32'h018F, 32'(microstep_pos));
    chk_bit("backward", 1'b0, step_forward);
    i_ctl.drive(1'b0, 1'b1);
    idle(8);
    chk_bit("phase off", 1'b0, phase_enable);
    i_ctl.pulse(2);
    idle(4);
    chk_val("pos disabled", 32'h018F, 32'(microstep_pos));
    $display("test steps done");
    i_ctl.drive(1'b1, 1'b1);
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    i_ctl.pulse(1);
    idle(4);
    chk_bit("irq", 1'b1, irq);
    apb(1'b0, 8'h08, 32'h0);
    chk_bit("step event", 1'b1, rd[0]);
    idle(2);
    chk_bit("irq cleared", 1'b0, irq);
    apb(1'b1, 8'h0C, 32'h0);
    i_ctl.pulse(1);
    idle(4);
    chk_bit("irq masked", 1'b0, irq);
    $display("test irq done");
    red_sw <= 1'b1;
    i_ctl.pulse(1);
    idle(2);
    chk_val("full current", 32'h1C20, 32'(phase_current_ma));
    idle(60);
    chk_val("reduced", 32'h10E0, 32'(phase_current_ma));
    i_ctl.pulse(1);
    idle(2);
    chk_val("restored", 32'h1C20, 32'(phase_current_ma));
    $display("test standstill done");
    // falling edge counted, direction inverted
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk_val("ctrl", 32'h3, rd);
    i_ctl.pulse(1);
    idle(8);
    chk_val("pos fall edge", 32'h2, 32'(microstep_pos));
    chk_bit("inverted", 1'b0, step_forward);
    $display("test edge mode done");
    power_fault <= 1'b1;
    idle(8);
    chk_bit("fault led", 1'b1, led_fault);
    chk_bit("fault phase", 1'b0, phase_enable);
    apb(1'b0, 8'h08, 32'h0);
    chk_bit("fault event", 1'b1, rd[1]);
    power_fault <= 1'b0;
    i_ctl.drive(1'b0, 1'b0);
    idle(8);
    i_ctl.drive(1'b1, 1'b1);
    i_ctl.pulse(2);
    idle(8);
    chk_bit("fault held", 1'b1, led_fault);
    chk_bit("phase held off", 1'b0, phase_enable);
    chk_val("pos in fault", 32'h2, 32'(microstep_pos));
    presetn <= 1'b0;
    idle(20);
    presetn <= 1'b1;
    idle(10);
    chk_bit("fault cleared", 1'b0, led_fault);
    chk_bit("power again", 1'b1, led_power);
    $display("test fault done");
    wrap_up;
  end
endmodule : microstep_drive_config_ctrl_test
